// ==== design/pig_level_select.sv ====
`timescale 1ns/100ps
module pig_level_select
  import pig_pkg::*;
#(
  parameter int NLEV = PIG_NUM_GROUPS * PIG_LEVELS_PER_GROUP,
  parameter int IDXW = $clog2(NLEV)
) (
  input wire logic [NLEV-1:0] requestVec,
  input wire logic [NLEV-1:0] enableVec,
  input wire logic [NLEV-1:0] activeVec,
  output logic anyQualify,
  output logic [IDXW-1:0] qualifyIdx,
  output logic anyActive,
  output logic [IDXW-1:0] topActiveIdx
);

  // Walk from highest priority down; a level qualifies only when no
  // higher level is active, so an active lockout level blocks all below
  always_comb begin
    logic blocked;
    blocked = 1'b0;
    anyQualify = 1'b0;
    qualifyIdx = '0;
    anyActive = 1'b0;
    topActiveIdx = '0;
    for (int n = 0; n < NLEV; n++) begin
      if (!anyQualify && !blocked && requestVec[n] && enableVec[n]) begin
        anyQualify = 1'b1;
        qualifyIdx = IDXW'(n);
      end
      if (!anyActive && activeVec[n]) begin
        anyActive = 1'b1;
        topActiveIdx = IDXW'(n);
      end
      blocked = blocked | activeVec[n];
    end
  end

endmodule // pig_level_select

// ==== design/pig_pkg.sv ====
package pig_pkg;

  // Interrupt structure: groups of levels, level 1 of group 0 is highest
  localparam int PIG_NUM_GROUPS = 8;
  localparam int PIG_LEVELS_PER_GROUP = 12;

  // Enable/disable operand word layout, bit 0 of the level field is level 1
  localparam int PIG_OPERAND_W = 16;
  localparam int PIG_GROUP_W = 3;
  localparam int PIG_GROUP_LSB = 12;
  localparam int PIG_LEVEL_LSB = 0;

  // Instruction class reported by the sequencer with each completion
  localparam int PIG_CODE_W = 3;
  typedef logic [PIG_CODE_W-1:0] pig_code_t;
  localparam pig_code_t PIG_CODE_OTHER = 3'h0;
  localparam pig_code_t PIG_CODE_RELEASE = 3'h1;
  localparam pig_code_t PIG_CODE_DISABLE = 3'h2;
  localparam pig_code_t PIG_CODE_ENABLE = 3'h3;
  localparam pig_code_t PIG_CODE_STORE_BRANCH = 3'h4;
  localparam pig_code_t PIG_CODE_COPY_SIGN = 3'h5;
  localparam pig_code_t PIG_CODE_RETURN = 3'h6;

  // Values after reset
  localparam logic PIG_CARRY_RST = 1'b0;
  localparam logic PIG_DEFER_RST = 1'b0;

  // Release-pair tracker
  typedef enum logic [1:0] {
    PIG_REL_IDLE = 2'b01,
    PIG_REL_ARMED = 2'b10
  } pig_rel_e;

endpackage

// ==== design/pig_priority_gating.sv ====
// Overview of operation
// - Enable on lockout level sets its active latch
// - Active lockout level blocks all lower levels
// - Disable naming lockout level clears its active
// - Lockout may sit at group 0 level 1
// - Five instruction kinds defer service one instruction
// - Release instruction lets return branch run first
// - Disable clears designated requests on second cycle
// - Carry cleared per instruction except after copy-sign
// - Level interrupts if requested, enabled, none higher active
// - Check between fetch and execute, set active
// - Release-return pair clears top active and request
// - Group field plus one-hot level field steer enables
`timescale 1ns/100ps
module pig_priority_gating
  import pig_pkg::*;
#(
  parameter int NUM_GROUPS = PIG_NUM_GROUPS,
  parameter int LEVELS = PIG_LEVELS_PER_GROUP,
  parameter int NLEV = NUM_GROUPS * LEVELS,
  parameter int IDXW = $clog2(NLEV)
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [NLEV-1:0] lockoutPresent,
  input wire logic [NLEV-1:0] extRequest,
  input wire logic instrDone,
  input wire pig_code_t instrCode,
  input wire logic [PIG_OPERAND_W-1:0] instrOperand,
  input wire logic disableCycle2,
  input wire logic checkReq,
  input wire logic carrySet,
  output logic intGrant,
  output logic [IDXW-1:0] intLevel,
  output logic intPending,
  output logic deferService,
  output logic [NLEV-1:0] requestLatch,
  output logic [NLEV-1:0] enableLatch,
  output logic [NLEV-1:0] activeLatch,
  output logic carryLatch
);

  // Turn a group number and a one-hot level field into a level vector
  function automatic logic [NLEV-1:0] levelMask(input logic [PIG_OPERAND_W-1:0] word);
    logic [NLEV-1:0] v;
    int grp;
    v = '0;
    grp = int'(word[PIG_GROUP_LSB +: PIG_GROUP_W]);
    if (grp < NUM_GROUPS) begin
      for (int j = 0; j < LEVELS; j++) begin
        v[grp * LEVELS + j] = word[PIG_LEVEL_LSB + j];
      end
    end
    return v;
  endfunction

  // One-hot vector for a level index
  function automatic logic [NLEV-1:0] oneHot(input logic [IDXW-1:0] idx);
    logic [NLEV-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  // Instructions after which no interrupt may be serviced
  function automatic logic holdsOff(input pig_code_t code);
    return (code == PIG_CODE_RELEASE) || (code == PIG_CODE_DISABLE) ||
           (code == PIG_CODE_ENABLE) || (code == PIG_CODE_STORE_BRANCH) ||
           (code == PIG_CODE_COPY_SIGN);
  endfunction

  logic [NLEV-1:0] request_q;
  logic [NLEV-1:0] enable_q;
  logic [NLEV-1:0] active_q;
  logic defer_q;
  logic grant_q;
  logic [IDXW-1:0] level_q;
  logic pending_q;
  logic carry_q;
  pig_rel_e rel_q;
  logic anyQualify;
  logic [IDXW-1:0] qualifyIdx;
  logic anyActive;
  logic [IDXW-1:0] topActiveIdx;
  logic [NLEV-1:0] opMask;
  logic enableNow;
  logic disableNow;
  logic grantNow;
  logic releaseNow;
  logic [NLEV-1:0] lockSet;
  logic [NLEV-1:0] lockClr;
  logic [NLEV-1:0] grantSet;
  logic [NLEV-1:0] relClr;
  logic [NLEV-1:0] reqClr;

  pig_level_select #(
    .NLEV(NLEV),
    .IDXW(IDXW)
  ) u_select (
    .requestVec(request_q),
    .enableVec(enable_q),
    .activeVec(active_q),
    .anyQualify(anyQualify),
    .qualifyIdx(qualifyIdx),
    .anyActive(anyActive),
    .topActiveIdx(topActiveIdx)
  );

  // Decode of the completing instruction and the grant decision
  assign opMask = levelMask(instrOperand);
  assign enableNow = instrDone && (instrCode == PIG_CODE_ENABLE);
  assign disableNow = instrDone && (instrCode == PIG_CODE_DISABLE);
  assign grantNow = checkReq && !defer_q && anyQualify;
  assign releaseNow = instrDone && (rel_q == PIG_REL_ARMED) &&
                      (instrCode == PIG_CODE_RETURN) && anyActive;
  assign lockSet = enableNow ? (opMask & lockoutPresent) : '0;
  assign lockClr = disableNow ? (opMask & lockoutPresent) : '0;
  assign grantSet = grantNow ? oneHot(qualifyIdx) : '0;
  assign relClr = releaseNow ? oneHot(topActiveIdx) : '0;
  assign reqClr = (disableCycle2 ? opMask : '0) | relClr;

  // Enable latches; a disable wins only for its own bits
  always_ff @(posedge clock) begin
    if (!rstn) begin
      enable_q <= '0;
    end else if (enableNow) begin
      enable_q <= enable_q | opMask;
    end else if (disableNow) begin
      enable_q <= enable_q & ~opMask;
    end
  end

  // Request latches; a source still asserting survives the clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      request_q <= '0;
    end else begin
      request_q <= (request_q & ~reqClr) | extRequest;
    end
  end

  // Active latches: set by grant or lockout enable, set beats clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      active_q <= '0;
    end else begin
      active_q <= (active_q & ~(lockClr | relClr)) | grantSet | lockSet;
    end
  end

  // Deferral; a chain keeps it set until an ordinary instruction ends
  always_ff @(posedge clock) begin
    if (!rstn) begin
      defer_q <= PIG_DEFER_RST;
    end else if (instrDone) begin
      defer_q <= holdsOff(instrCode);
    end
  end

  // Release-pair tracker: only a return right after release clears
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rel_q <= PIG_REL_IDLE;
    end else if (instrDone) begin
      case (rel_q)
        PIG_REL_IDLE: begin
          rel_q <= (instrCode == PIG_CODE_RELEASE) ? PIG_REL_ARMED : PIG_REL_IDLE;
        end
        PIG_REL_ARMED: begin
          rel_q <= (instrCode == PIG_CODE_RELEASE) ? PIG_REL_ARMED : PIG_REL_IDLE;
        end
        default: begin
          rel_q <= PIG_REL_IDLE;
        end
      endcase
    end
  end

  // Grant answer to the sequencer, one cycle after the check
  always_ff @(posedge clock) begin
    if (!rstn) begin
      grant_q <= 1'b0;
      level_q <= '0;
      pending_q <= 1'b0;
    end else begin
      grant_q <= grantNow;
      pending_q <= anyQualify && !defer_q;
      if (grantNow) begin
        level_q <= qualifyIdx;
      end
    end
  end

  // Carry latch; the ALU set wins over the end-of-instruction clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      carry_q <= PIG_CARRY_RST;
    end else if (carrySet) begin
      carry_q <= 1'b1;
    end else if (instrDone && (instrCode != PIG_CODE_COPY_SIGN)) begin
      carry_q <= 1'b0;
    end
  end

  assign intGrant = grant_q;
  assign intLevel = level_q;
  assign intPending = pending_q;
  assign deferService = defer_q;
  assign requestLatch = request_q;
  assign enableLatch = enable_q;
  assign activeLatch = active_q;
  assign carryLatch = carry_q;

  // Checks on the gating behaviour
  AST_LOCKOUT_SET: assert property (@(posedge clock) disable iff (!rstn)
    (|lockSet) |=> ((active_q & $past(lockSet)) == $past(lockSet)))
    else $error("lockout enable did not set active latch");

  AST_LOCKOUT_BLOCKS: assert property (@(posedge clock) disable iff (!rstn)
    (lockoutPresent[0] && active_q[0] && checkReq) |=> !grant_q)
    else $error("grant issued below an active lockout level");

  AST_LOCKOUT_CLEAR: assert property (@(posedge clock) disable iff (!rstn)
    ((|lockClr) && !grantNow) |=> ((active_q & $past(lockClr)) == '0))
    else $error("lockout disable did not clear active latch");

  AST_DEFER_SET: assert property (@(posedge clock) disable iff (!rstn)
    (instrDone && holdsOff(instrCode)) |=> (defer_q && !grant_q) ##1 !grant_q[*1])
    else $error("deferral not raised after hold-off instruction");

  AST_DEFER_BLOCK: assert property (@(posedge clock) disable iff (!rstn)
    (defer_q && checkReq) |=> !grant_q)
    else $error("interrupt serviced while deferred");

  AST_DEFER_END: assert property (@(posedge clock) disable iff (!rstn)
    (instrDone && !holdsOff(instrCode)) |=> !defer_q)
    else $error("deferral outlived the chain");

  AST_DISABLE_REQ: assert property (@(posedge clock) disable iff (!rstn)
    (disableCycle2 && ((opMask & extRequest) == '0)) |=>
      ((request_q & $past(opMask)) == '0))
    else $error("disable did not clear request latches");

  AST_CARRY: assert property (@(posedge clock) disable iff (!rstn)
    (instrDone && (instrCode != PIG_CODE_COPY_SIGN) && !carrySet) |=> !carry_q)
    else $error("carry survived a non copy-sign instruction");

  AST_CARRY_KEEP: assert property (@(posedge clock) disable iff (!rstn)
    (instrDone && (instrCode == PIG_CODE_COPY_SIGN) && carry_q) |=> carry_q)
    else $error("carry lost after copy-sign");

  AST_GRANT: assert property (@(posedge clock) disable iff (!rstn)
    (checkReq && !defer_q && anyQualify) |=>
      (grant_q && active_q[level_q] && (level_q == $past(qualifyIdx))))
    else $error("qualifying interrupt not granted");

  AST_RELEASE: assert property (@(posedge clock) disable iff (!rstn)
    (releaseNow && !grantNow && !(|lockSet)) |=> !active_q[$past(topActiveIdx)])
    else $error("release pair did not clear top active latch");

  AST_ENABLE: assert property (@(posedge clock) disable iff (!rstn)
    enableNow |=> ((enable_q & $past(opMask)) == $past(opMask)))
    else $error("enable latches not set");

endmodule // pig_priority_gating

// ==== sim/pig_seq_model.sv ====
`timescale 1ns/100ps
// Instruction sequencer stand-in; every strobe lasts exactly one cycle
module pig_seq_model
  import pig_pkg::*;
(
  input wire logic clock,
  output logic instrDone,
  output pig_code_t instrCode,
  output logic [PIG_OPERAND_W-1:0] instrOperand,
  output logic disableCycle2,
  output logic checkReq,
  output logic carrySet
);
  initial begin
    {instrDone, disableCycle2, checkReq, carrySet} = 4'h0;
    instrCode = PIG_CODE_OTHER;
    instrOperand = 16'h0;
  end

  // Kind 0 completion, 1 disable second cycle, 2 check, 3 carry
  task automatic strobe(input int k, input pig_code_t c, input logic [15:0] op);
    @(negedge clock);
    instrCode = c;
    instrOperand = op;
    instrDone = (k == 0);
    disableCycle2 = (k == 1);
    checkReq = (k == 2);
    carrySet = (k == 3);
    @(negedge clock);
    {instrDone, disableCycle2, checkReq, carrySet} = 4'h0;
    // Stale operand scrambled so nobody can lean on it
    instrOperand = ~op;
  endtask
endmodule // pig_seq_model

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top
  import pig_pkg::*;
;
  typedef struct packed {
    pig_code_t code;
    logic [15:0] op;
    logic defer;
  } pig_row_s;
  logic clock, rstn, intGrant, intPending, deferService, carryLatch;
  logic [95:0] extRequest, requestLatch, enableLatch, activeLatch, lockCard;
  logic [6:0] intLevel;
  logic instrDone, disableCycle2, checkReq, carrySet;
  pig_code_t instrCode;
  logic [15:0] instrOperand;
  int fails = 0;
  int num_checks = 0;
  // Completion class, operand, expected deferral afterwards
  pig_row_s rows [9] = '{
    '{PIG_CODE_ENABLE, 16'h201f, 1'b1}, '{PIG_CODE_OTHER, 16'h0, 1'b0},
    '{PIG_CODE_RELEASE, 16'h0, 1'b1}, '{PIG_CODE_STORE_BRANCH, 16'h0, 1'b1},
    '{PIG_CODE_OTHER, 16'h0, 1'b0}, '{PIG_CODE_COPY_SIGN, 16'h0, 1'b1},
    '{PIG_CODE_RETURN, 16'h0, 1'b0}, '{PIG_CODE_DISABLE, 16'h2010, 1'b1},
    '{PIG_CODE_OTHER, 16'h0, 1'b0}};

  pig_seq_model seq (.clock(clock), .instrDone(instrDone), .instrCode(instrCode),
    .instrOperand(instrOperand), .disableCycle2(disableCycle2), .checkReq(checkReq),
    .carrySet(carrySet));

  // Lockout card position is a strap; the bench moves it once, between tests
  pig_priority_gating DUT (.clock(clock), .rstn(rstn), .lockoutPresent(lockCard),
    .extRequest(extRequest), .instrDone(instrDone), .instrCode(instrCode),
    .instrOperand(instrOperand), .disableCycle2(disableCycle2), .checkReq(checkReq),
    .carrySet(carrySet), .intGrant(intGrant), .intLevel(intLevel),
    .intPending(intPending), .deferService(deferService), .requestLatch(requestLatch),
    .enableLatch(enableLatch), .activeLatch(activeLatch), .carryLatch(carryLatch));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ins(input pig_code_t c, input logic [15:0] op);
    seq.strobe(0, c, op);
  endtask

  // One-cycle source pulse; too short to outlive a disable
  task automatic req(input int n);
    @(negedge clock);
    extRequest[n] = 1'b1;
    @(negedge clock);
    extRequest = '0;
  endtask

  task automatic chkGrant(input logic g, input int lvl);
    seq.strobe(2, PIG_CODE_OTHER, 16'h0);
    chk(intGrant, g);
    if (g) chk(intLevel, lvl);
  endtask

  // Hang guard, well beyond the hundred or so cycles the tests need
  initial begin
    #(25 * 2000);
    fails++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin
    rstn = 1'b0;
    extRequest = '0;
    lockCard = 96'h1;
    repeat (3) @(negedge clock);
    chk(requestLatch | enableLatch | activeLatch, 96'h0);
    chk({intGrant, intLevel, intPending, deferService, carryLatch}, 96'h0);
    rstn = 1'b1;
    @(negedge clock);
    $display("test reset done");
    foreach (rows[i]) begin
      ins(rows[i].code, rows[i].op);
      chk(deferService, rows[i].defer);
    end
    chk(enableLatch, 96'hf << 24);
    chk(activeLatch, 96'h0);
    $display("test table done");
    req(25);
    chkGrant(1'b1, 25);
    chk(activeLatch[25], 1'b1);
    req(24);
    ins(PIG_CODE_RELEASE, 16'h0);
    chkGrant(1'b0, 0);
    ins(PIG_CODE_RETURN, 16'h0);
    chk({activeLatch[25], requestLatch[25]}, 2'b00);
    chkGrant(1'b1, 24);
    // A return with no release just before it must leave the level active
    ins(PIG_CODE_RETURN, 16'h0);
    chk(activeLatch[24], 1'b1);
    ins(PIG_CODE_RELEASE, 16'h0);
    ins(PIG_CODE_RETURN, 16'h0);
    $display("test grant done");
    ins(PIG_CODE_ENABLE, 16'h0001);
    chk(activeLatch[0], 1'b1);
    ins(PIG_CODE_OTHER, 16'h0);
    req(26);
    chkGrant(1'b0, 0);
    chk(intPending, 1'b0);
    ins(PIG_CODE_DISABLE, 16'h0001);
    chk(activeLatch[0], 1'b0);
    ins(PIG_CODE_OTHER, 16'h0);
    chkGrant(1'b1, 26);
    chk(intPending, 1'b1);
    ins(PIG_CODE_RELEASE, 16'h0);
    ins(PIG_CODE_RETURN, 16'h0);
    $display("test lockout done");
    req(27);
    chk(requestLatch[27], 1'b1);
    seq.strobe(1, PIG_CODE_DISABLE, 16'h2008);
    chk(requestLatch[27], 1'b0);
    // A source that keeps asserting outlives the disable
    @(negedge clock);
    extRequest[27] = 1'b1;
    seq.strobe(1, PIG_CODE_DISABLE, 16'h2008);
    chk(requestLatch[27], 1'b1);
    extRequest = '0;
    ins(PIG_CODE_DISABLE, 16'h2008);
    $display("test disable done");
    seq.strobe(3, PIG_CODE_OTHER, 16'h0);
    ins(PIG_CODE_COPY_SIGN, 16'h0);
    chk(carryLatch, 1'b1);
    ins(PIG_CODE_OTHER, 16'h0);
    chk(carryLatch, 1'b0);
    $display("test carry done");
    // Card moved to group 2 level 3; level 4 below it must wait
    lockCard = 96'h1 << 26;
    req(27);
    ins(PIG_CODE_ENABLE, 16'h2008);
    ins(PIG_CODE_ENABLE, 16'h2004);
    chk(activeLatch[26], 1'b1);
    ins(PIG_CODE_OTHER, 16'h0);
    chkGrant(1'b0, 0);
    ins(PIG_CODE_DISABLE, 16'h2004);
    chk(activeLatch[26], 1'b0);
    ins(PIG_CODE_OTHER, 16'h0);
    chkGrant(1'b1, 27);
    $display("test moved card done");
    // Reset in mid-run must drop every latch the last test left set
    @(negedge clock);
    rstn = 1'b0;
    @(negedge clock);
    chk(requestLatch | enableLatch | activeLatch, 96'h0);
    chk({intGrant, intLevel, intPending, deferService, carryLatch}, 96'h0);
    rstn = 1'b1;
    @(negedge clock);
    $display("test midrun reset done");
    tally_and_finish();
  end
endmodule // tb_top
